// ### flash_sr_pkg.sv
// Purpose: Shared constants and types for the flash status/protect block
// Assumes: 100 MHz core clock, 4-byte addressing of a 1Gb array
// Notes: Opcodes and cycle times are plain defaults, adjust per product
package flash_sr_pkg;

  // ****************************************
  // Status register layout
  // ****************************************
  localparam int SR_LOCK = 7;
  localparam int SR_BP3 = 6;
  localparam int SR_TB = 5;
  localparam int SR_BP_HI = 4;
  localparam int SR_BP_LO = 2;
  localparam int SR_WEL = 1;
  localparam int SR_BUSY = 0;
  localparam logic [7:0] SR_NV_MASK = 8'hFC;
  localparam logic [7:0] SR_NV_RESET = 8'h00;

  // Flag status layout
  localparam int FSR_READY = 7;
  localparam int FSR_PROT = 1;
  localparam int FSR_ADDR4 = 0;

  // ****************************************
  // Command opcodes
  // ****************************************
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_ERASE4K = 8'h20;
  localparam logic [7:0] CMD_CLFSR = 8'h50;
  localparam logic [7:0] CMD_ERASE32K = 8'h52;
  localparam logic [7:0] CMD_RDFSR = 8'h70;
  localparam logic [7:0] CMD_DIE = 8'hC4;
  localparam logic [7:0] CMD_ERASE64K = 8'hD8;

  // Byte counts of complete frames
  localparam logic [2:0] LEN_OPCODE = 3'h1;
  localparam logic [2:0] LEN_WRSR = 3'h2;
  localparam logic [2:0] LEN_ADDR = 3'h5;
  localparam logic [2:0] LEN_PROG = 3'h6;
  localparam logic [2:0] LEN_MAX = 3'h7;

  // ****************************************
  // Array map
  // ****************************************
  localparam int SECTOR_MSB = 26;
  localparam int SECTOR_LSB = 16;
  localparam int SUB32_LSB = 15;
  localparam int SUB4_LSB = 12;
  localparam logic [11:0] SECTOR_COUNT = 12'h800;
  localparam logic [3:0] BP_NONE = 4'h0;
  localparam logic [3:0] BP_ALL = 4'hC;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int WRSR_TIME_US = 100;
  localparam int PROG_TIME_US = 100;
  localparam int ERASE_TIME_US = 1000;
  localparam int WRSR_CYCLES = WRSR_TIME_US * CLK_MHZ;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int BUSY_W = 24;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_WRSR = 3'b001,
    OP_PROG = 3'b010,
    OP_ERASE4K = 3'b011,
    OP_ERASE32K = 3'b100,
    OP_ERASE64K = 3'b101,
    OP_DIE = 3'b110
  } op_kind_e;

  typedef struct packed {
    logic valid;
    op_kind_e kind;
    logic [31:0] addr;
    logic [10:0] sector;
    logic [11:0] sub32;
    logic [14:0] sub4;
  } array_op_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_IN = 2'b01,
    ST_OUT = 2'b10
  } link_state_e;

endpackage : flash_sr_pkg

// ### flash_status_write_protect.sv
// Purpose: Status register, write lock and block protection of a NOR flash
// Assumes: SPI mode 0, single-bit, link pins sampled by i_mclk
// Notes: Commands other than reads act when chip select rises; the array itself is outside
//
// Summary of operation
// RL1: Read status and write status commands supported
// RL2: Lock bit with protect pin low blocks writes
// RL3: Only protect pin high leaves hardware lock
// RL4: Lock bit nonvolatile, zero permits status writes
// RL5: Bit five picks top or bottom region
// RL6: Block protect bits reject program and erase
// RL7: Write enable latch cleared at power-up
// RL8: Modify operations need write enable latch set
// RL9: Bit zero shows busy during internal cycles
// RL10: Die erase only when protect bits zero
// RL11: Busy bit is inverse of flag ready
// RL12: Addresses decode into sectors and subsectors linearly
// RL13: Protected size doubles per code step
// RL14: Flag ready bit tracks internal cycles automatically
// RL15: Nonvolatile bits survive reset pin; volatile cleared
`timescale 1ns/1ps
module flash_status_write_protect #(
  parameter int WRSR_CYCLES = flash_sr_pkg::WRSR_CYCLES,
  parameter int PROG_CYCLES = flash_sr_pkg::PROG_CYCLES,
  parameter int ERASE_CYCLES = flash_sr_pkg::ERASE_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_reset_pin_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic i_wp_n,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_busy,
  output logic [7:0] o_status,
  output flash_sr_pkg::array_op_s o_op
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] sync1, sync2;
  logic sclk_d, cs_d;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1 <= 5'h1A;
      sync2 <= 5'h1A;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sync1 <= {i_reset_pin_n, i_wp_n, i_mosi, i_cs_n, i_sclk};
      sync2 <= sync1;
      sclk_d <= sync2[0];
      cs_d <= sync2[1];
    end
  end

  wire s_sclk = sync2[0];
  wire s_cs_n = sync2[1];
  wire s_mosi = sync2[2];
  wire s_wp_n = sync2[3];
  wire s_rst_n = sync2[4];
  wire sclk_rise = s_sclk & ~sclk_d & ~s_cs_n;
  wire sclk_fall = ~s_sclk & sclk_d & ~s_cs_n;
  wire cs_fall = ~s_cs_n & cs_d;
  wire cs_rise = s_cs_n & ~cs_d;

  // ****************************************
  // Protection decode
  // ****************************************
  function automatic logic is_protected(input logic [10:0] sector,
                                        input logic [3:0] bp,
                                        input logic tb);
    logic [11:0] n;
    logic prot;
    n = 12'h001 << (bp - 4'h1);
    if (bp == flash_sr_pkg::BP_NONE) begin
      prot = 1'b0;
    end else if (bp >= flash_sr_pkg::BP_ALL) begin
      prot = 1'b1; // RL13
    end else if (tb) begin
      prot = {1'b0, sector} < n; // RL5
    end else begin
      prot = {1'b0, sector} >= (flash_sr_pkg::SECTOR_COUNT - n); // RL13
    end
    return prot;
  endfunction : is_protected

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] nv_bits;
  logic wel, busy, prot_err;
  logic [flash_sr_pkg::BUSY_W-1:0] busy_cnt;
  flash_sr_pkg::link_state_e state;
  logic [6:0] shift_in;
  logic [2:0] bit_cnt, byte_cnt, out_cnt;
  logic [7:0] opcode, wr_data, out_sr;
  logic [31:0] addr;

  wire [3:0] bp = {nv_bits[flash_sr_pkg::SR_BP3],
                   nv_bits[flash_sr_pkg::SR_BP_HI:flash_sr_pkg::SR_BP_LO]};
  wire tb = nv_bits[flash_sr_pkg::SR_TB];
  wire hw_locked = nv_bits[flash_sr_pkg::SR_LOCK] & ~s_wp_n; // RL2 RL3 RL4
  wire [7:0] status = {nv_bits[7:2], wel, busy}; // RL9
  wire [7:0] flag_status = {~busy, 5'h00, prot_err, 1'b1}; // RL11 RL14
  wire [7:0] in_byte = {shift_in, s_mosi};
  wire read_cmd = (in_byte == flash_sr_pkg::CMD_RDSR) |
                  (in_byte == flash_sr_pkg::CMD_RDFSR);
  wire [7:0] read_value = (opcode == flash_sr_pkg::CMD_RDFSR) ?
                          flag_status : status; // RL1
  wire [10:0] sector = addr[flash_sr_pkg::SECTOR_MSB:flash_sr_pkg::SECTOR_LSB];
  wire addr_prot = is_protected(sector, bp, tb); // RL6

  // ****************************************
  // Command decode at deselect
  // ****************************************
  wire exec = cs_rise & (bit_cnt == 3'h0) & ~busy; // Reads need no busy check
  wire one_byte = exec & (byte_cnt == flash_sr_pkg::LEN_OPCODE);
  wire do_wren = one_byte & (opcode == flash_sr_pkg::CMD_WREN);
  wire do_wrdi = one_byte & (opcode == flash_sr_pkg::CMD_WRDI);
  wire do_clfsr = one_byte & (opcode == flash_sr_pkg::CMD_CLFSR);
  wire do_wrsr = exec & wel & ~hw_locked & // RL2 RL8
                 (opcode == flash_sr_pkg::CMD_WRSR) &
                 (byte_cnt == flash_sr_pkg::LEN_WRSR);
  wire is_erase = (opcode == flash_sr_pkg::CMD_ERASE4K) |
                  (opcode == flash_sr_pkg::CMD_ERASE32K) |
                  (opcode == flash_sr_pkg::CMD_ERASE64K);
  wire try_addr = exec & wel & // RL8
                  (((opcode == flash_sr_pkg::CMD_PROG) &
                    (byte_cnt >= flash_sr_pkg::LEN_PROG)) |
                   (is_erase & (byte_cnt == flash_sr_pkg::LEN_ADDR)));
  wire try_die = one_byte & wel & (opcode == flash_sr_pkg::CMD_DIE);
  wire die_ok = (bp == flash_sr_pkg::BP_NONE); // RL10
  wire start_addr = try_addr & ~addr_prot; // RL6
  wire start_die = try_die & die_ok; // RL10
  wire refuse = (try_addr & addr_prot) | (try_die & ~die_ok);
  wire start_op = do_wrsr | start_addr | start_die;

  flash_sr_pkg::op_kind_e next_kind;
  logic [31:0] next_mask;
  logic [flash_sr_pkg::BUSY_W-1:0] next_busy_cnt;

  always_comb begin
    next_kind = flash_sr_pkg::OP_NONE;
    next_mask = 32'hFFFFFFFF;
    next_busy_cnt = flash_sr_pkg::BUSY_W'(ERASE_CYCLES);
    case (opcode)
      flash_sr_pkg::CMD_WRSR: begin
        next_kind = flash_sr_pkg::OP_WRSR;
        next_busy_cnt = flash_sr_pkg::BUSY_W'(WRSR_CYCLES);
      end
      flash_sr_pkg::CMD_PROG: begin
        next_kind = flash_sr_pkg::OP_PROG;
        next_busy_cnt = flash_sr_pkg::BUSY_W'(PROG_CYCLES);
      end
      flash_sr_pkg::CMD_ERASE4K: begin
        next_kind = flash_sr_pkg::OP_ERASE4K;
        next_mask = ~((32'h1 << flash_sr_pkg::SUB4_LSB) - 32'h1); // RL12
      end
      flash_sr_pkg::CMD_ERASE32K: begin
        next_kind = flash_sr_pkg::OP_ERASE32K;
        next_mask = ~((32'h1 << flash_sr_pkg::SUB32_LSB) - 32'h1); // RL12
      end
      flash_sr_pkg::CMD_ERASE64K: begin
        next_kind = flash_sr_pkg::OP_ERASE64K;
        next_mask = ~((32'h1 << flash_sr_pkg::SECTOR_LSB) - 32'h1); // RL12
      end
      flash_sr_pkg::CMD_DIE: begin
        next_kind = flash_sr_pkg::OP_DIE;
        next_mask = 32'h00000000;
      end
      default: next_kind = flash_sr_pkg::OP_NONE;
    endcase
  end

  wire [31:0] op_addr = addr & next_mask;

  // ****************************************
  // Nonvolatile bits: reset pin leaves them alone
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      nv_bits <= flash_sr_pkg::SR_NV_RESET; // RL4 RL5
    end else if (do_wrsr) begin
      nv_bits <= wr_data & flash_sr_pkg::SR_NV_MASK; // RL1 RL15
    end
  end

  // ****************************************
  // Volatile control and busy timer
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wel <= 1'b0; // RL7
      busy <= 1'b0;
      busy_cnt <= '0;
      prot_err <= 1'b0;
      o_op <= '0;
    end else if (!s_rst_n) begin
      wel <= 1'b0; // RL15
      busy <= 1'b0; // RL15
      busy_cnt <= '0;
      prot_err <= 1'b0;
      o_op <= '0;
    end else begin
      o_op.valid <= start_addr | start_die;
      if (start_addr | start_die) begin
        o_op.kind <= next_kind;
        o_op.addr <= op_addr;
        o_op.sector <= op_addr[26:16]; // RL12
        o_op.sub32 <= op_addr[26:15];
        o_op.sub4 <= op_addr[26:12];
      end
      if (start_op) begin
        busy <= 1'b1; // RL9 RL14
        busy_cnt <= next_busy_cnt;
      end else if (busy) begin
        busy_cnt <= busy_cnt - 1'b1;
        if (busy_cnt == flash_sr_pkg::BUSY_W'(1)) begin
          busy <= 1'b0; // RL14
          wel <= 1'b0;
        end
      end
      if (do_wren) begin
        wel <= 1'b1; // RL8
      end else if (do_wrdi) begin
        wel <= 1'b0;
      end
      // Only one command per frame, so set and clear never collide
      if (refuse) begin
        prot_err <= 1'b1;
      end else if (do_clfsr) begin
        prot_err <= 1'b0;
      end
    end
  end

  // ****************************************
  // Serial link
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= flash_sr_pkg::ST_IDLE;
      shift_in <= '0;
      bit_cnt <= '0;
      byte_cnt <= '0;
      opcode <= '0;
      addr <= '0;
      wr_data <= '0;
      out_sr <= '0;
      out_cnt <= '0;
      o_miso <= 1'b0;
    end else if (s_cs_n || !s_rst_n) begin
      state <= flash_sr_pkg::ST_IDLE;
      bit_cnt <= '0;
    end else if (cs_fall) begin
      state <= flash_sr_pkg::ST_IN;
      bit_cnt <= '0;
      byte_cnt <= '0;
      opcode <= '0;
    end else if (sclk_rise && state == flash_sr_pkg::ST_IN) begin
      shift_in <= in_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (byte_cnt != flash_sr_pkg::LEN_MAX) begin
          byte_cnt <= byte_cnt + 3'h1;
        end
        if (byte_cnt == 3'h0) begin
          opcode <= in_byte;
          if (read_cmd) begin
            state <= flash_sr_pkg::ST_OUT; // RL1
            out_sr <= (in_byte == flash_sr_pkg::CMD_RDFSR) ?
                      flag_status : status;
            out_cnt <= '0;
          end
        end else if (byte_cnt < flash_sr_pkg::LEN_ADDR) begin
          addr <= {addr[23:0], in_byte};
          wr_data <= in_byte; // Only a two-byte frame uses it
        end
      end
    end else if (sclk_fall && state == flash_sr_pkg::ST_OUT) begin
      o_miso <= out_sr[7];
      out_cnt <= out_cnt + 3'h1;
      // Reload per byte so a polling read sees busy drop live
      out_sr <= (out_cnt == 3'h7) ? read_value : {out_sr[6:0], 1'b0};
    end
  end

  assign o_miso_oe = (state == flash_sr_pkg::ST_OUT) & ~s_cs_n;
  assign o_busy = busy;
  assign o_status = status;

endmodule : flash_status_write_protect

// ### flash_sr_properties.sv
// Purpose: Port checks for the flash status and protect block
// Assumes: One core clock domain, asynchronous active-low reset
// Notes: Link pins are seen raw, so bounds allow for the sync stages
`timescale 1ns/1ps
module flash_sr_properties #(
  parameter int WRSR_CYCLES = 300,
  parameter int PROG_CYCLES = 300,
  parameter int ERASE_CYCLES = 600
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_reset_pin_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic i_wp_n,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire logic o_busy,
  input wire logic [7:0] o_status,
  input wire flash_sr_pkg::array_op_s o_op
);
  localparam int MIN_C = (WRSR_CYCLES < PROG_CYCLES) ? WRSR_CYCLES
                                                      : PROG_CYCLES;
  // Busy length counter, so long waits need no long repetitions
  int busy_cnt;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= o_busy ? busy_cnt + 1 : 0;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  a_busy_bit: assert property (o_busy == o_status[0])
    else $error("busy port differs from status bit 0");
  a_op_wel: assert property (o_op.valid |->
    o_status[1] && o_busy && !$past(o_busy))
    else $error("operation issued without latch or while busy");
  a_die_clear: assert property (o_op.valid &&
    o_op.kind == flash_sr_pkg::OP_DIE |-> {o_status[6], o_status[4:2]} == 4'h0)
    else $error("die erase issued with protect bits set");
  a_reset_clear: assert property ($rose(i_rstn) |->
    o_status == 8'h00 && !o_busy)
    else $error("status not clear after reset");
  a_lock_hold: assert property ((o_status[7] && !i_wp_n) [*6] |=>
    $stable(o_status[7:2]))
    else $error("locked status bits changed");
  a_pin_clear: assert property (!i_reset_pin_n [*5] |->
    !o_status[1] && !o_busy && $stable(o_status[7:2]))
    else $error("reset pin handling of status wrong");
  a_busy_min: assert property ($fell(o_busy) |->
    busy_cnt >= MIN_C - 1)
    else $error("busy ended too early");
  a_busy_max: assert property (busy_cnt <= ERASE_CYCLES + 1)
    else $error("busy lasted too long");
  a_oe_release: assert property ($rose(i_cs_n) |->
    ##[1:5] !o_miso_oe)
    else $error("output enable held after deselect");
  a_oe_select: assert property (o_miso_oe |-> !$past(i_cs_n, 2))
    else $error("output enable high while deselected");
  a_miso_fall: assert property ($changed(o_miso) |->
    !$past(i_sclk, 3) && $past(i_sclk, 4))
    else $error("data out changed away from a link clock fall");
endmodule : flash_sr_properties
bind flash_status_write_protect flash_sr_properties #(
  .WRSR_CYCLES(WRSR_CYCLES), .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)) props (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_reset_pin_n(i_reset_pin_n),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_mosi(i_mosi), .i_wp_n(i_wp_n),
  .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_busy(o_busy),
  .o_status(o_status), .o_op(o_op));

// ### spi_host_model.sv
// Purpose: Serial host that frames commands for the flash block
// Assumes: Mode 0, MSB first, 80 ns link period
// Notes: Link clock idles low; data line inverts when released
`timescale 1ns/1ps
module spi_host_model (
  input wire logic i_mclk,
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Four core cycles per half period gives the 80 ns link clock
  task automatic half;
    repeat (4) @(posedge i_mclk);
    #1;
  endtask : half
  task automatic frame(input logic [55:0] d, input int nb,
                       output logic [7:0] rx);
    rx = 8'h00;
    half();
    o_cs_n = 1'b0;
    for (int i = 0; i < nb * 8; i++) begin
      o_mosi = d[55 - i];
      half();
      rx = {rx[6:0], i_miso};
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    half();
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    half();
  endtask : frame
endmodule : spi_host_model

// ### flash_status_write_protect_tb_top.sv
// Purpose: Self-checking bench for the flash status and protect block
// Assumes: Host model frames every command
// Notes: Busy times are shortened through parameters
`timescale 1ns/1ps
module flash_status_write_protect_tb_top;
  localparam int WRSR_C = 300;
  localparam int PROG_C = 300;
  localparam int ERASE_C = 600;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic rst_pin_n = 1'b1;
  logic wp_n = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe, busy;
  logic [7:0] status, rx;
  flash_sr_pkg::array_op_s op, last_op;
  int fail_count = 0;
  int n_tests = 0;
  int ops = 0;
  wire logic miso_line = miso_oe ? miso : ~miso;
  logic [7:0] t_sr [10] = '{8'h24, 8'h24, 8'h24, 8'h04, 8'h04, 8'h70,
                            8'h4C, 8'h4C, 8'h00, 8'h00};
  logic [7:0] t_cmd [10] = '{8'hD8, 8'hD8, 8'hC4, 8'h20, 8'h20, 8'h52,
                             8'hD8, 8'hD8, 8'h02, 8'hC4};
  logic [31:0] t_adr [10] = '{32'h0, 32'h0001_0000, 32'h0, 32'h07FF_F000,
    32'h07FE_F000, 32'h0400_0000, 32'h03FF_0000, 32'h0400_0000,
    32'h0000_0100, 32'h0};
  logic [9:0] t_ok = 10'b11_0101_0010;
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (op.valid === 1'b1) begin
      last_op <= op;
      ops <= ops + 1;
    end
  end
  flash_status_write_protect #(.WRSR_CYCLES(WRSR_C), .PROG_CYCLES(PROG_C),
    .ERASE_CYCLES(ERASE_C)) dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_reset_pin_n(rst_pin_n),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .i_wp_n(wp_n),
    .o_miso(miso), .o_miso_oe(miso_oe), .o_busy(busy),
    .o_status(status), .o_op(op));
  spi_host_model host (.i_mclk(i_mclk), .i_miso(miso_line), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_mosi(mosi));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic send(input logic [55:0] d, input int nb);
    host.frame(d, nb, rx);
  endtask : send
  task automatic wait_ready;
    for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge i_mclk);
    #1;
    if (busy !== 1'b0) begin
      fail_count++;
      end_of_test();
    end
  endtask : wait_ready
  task automatic wren;
    send({flash_sr_pkg::CMD_WREN, 48'h0}, 1);
    repeat (4) @(posedge i_mclk);
  endtask : wren
  task automatic wrsr(input logic [7:0] v);
    wren();
    send({flash_sr_pkg::CMD_WRSR, v, 40'h0}, 2);
    wait_ready();
  endtask : wrsr
  // Opcode alone for die erase, one data byte for program
  task automatic try_op(input logic [7:0] c, input logic [31:0] a,
                        input logic ok);
    int n0;
    n0 = ops;
    wren();
    send({c, a, 16'h0}, c == flash_sr_pkg::CMD_DIE ? 1 :
         c == flash_sr_pkg::CMD_PROG ? 6 : 5);
    repeat (4) @(posedge i_mclk);
    check(ops - n0, ok);
    check(busy, ok);
    wait_ready();
  endtask : try_op
  initial begin
    repeat (10) @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    repeat (3) @(posedge i_mclk);
    check(status, 8'h00);
    send({flash_sr_pkg::CMD_WRSR, 8'h20, 40'h0}, 2);
    repeat (8) @(posedge i_mclk);
    check(status, 8'h00);
    wren();
    check(status, 8'h02);
    send({flash_sr_pkg::CMD_WRSR, 8'h20, 40'h0}, 2);
    repeat (4) @(posedge i_mclk);
    check(busy, 1'b1);
    send({flash_sr_pkg::CMD_RDFSR, 48'h0}, 2);
    check({rx[7], status[0]}, 2'b01);
    wait_ready();
    check(status, 8'h20);
    send({flash_sr_pkg::CMD_RDSR, 48'h0}, 2);
    check(rx, 8'h20);
    send({flash_sr_pkg::CMD_RDFSR, 48'h0}, 2);
    check(rx[7], 1'b1);
    for (int i = 0; i < 10; i++) begin
      if (i == 0 || t_sr[i] != t_sr[i - 1]) wrsr(t_sr[i]);
      try_op(t_cmd[i], t_adr[i], t_ok[i]);
      if (i == 4) begin
        check(last_op.addr, 32'h07FE_F000);
        check({last_op.sector, last_op.sub32}, {11'h7FE, 12'hFFD});
        check(last_op.sub4, 15'h7FEF);
      end
    end
    check(last_op.kind, flash_sr_pkg::OP_DIE);
    send({flash_sr_pkg::CMD_RDFSR, 48'h0}, 2);
    check(rx[1], 1'b1);
    send({flash_sr_pkg::CMD_CLFSR, 48'h0}, 1);
    send({flash_sr_pkg::CMD_RDFSR, 48'h0}, 2);
    check(rx, 8'h81);
    wren();
    send({flash_sr_pkg::CMD_WRDI, 48'h0}, 1);
    check(status[1], 1'b0);
    wrsr(8'h80);
    check(status, 8'h80);
    wp_n = 1'b0;
    wren();
    send({flash_sr_pkg::CMD_WRSR, 8'h00, 40'h0}, 2);
    repeat (8) @(posedge i_mclk);
    check(status & 8'hFD, 8'h80);
    #1 wp_n = 1'b1;
    wrsr(8'h00);
    check(status, 8'h00);
    wrsr(8'h24);
    wren();
    #1 rst_pin_n = 1'b0;
    repeat (6) @(posedge i_mclk);
    #1 rst_pin_n = 1'b1;
    repeat (4) @(posedge i_mclk);
    check(status, 8'h24);
    #1 i_rstn = 1'b0;
    @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    check(status, 8'h00);
    repeat (3) @(posedge i_mclk);
    end_of_test();
  end
endmodule : flash_status_write_protect_tb_top
